// ===== flash_program_erase_protect.sv
// flash program, erase and block-protect sequencer with an ahb-lite slave
//
// The placing of the registers and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ps

module flash_program_erase_protect
	import flash_seq_pkg::*;
#(
	// arbitrary neutral default, address of the protect byte in the array
	parameter logic [15:0] PROT_BYTE_ADDR = 16'hFF00
)
(
	input  wire logic                      sys_clk_in,
	input  wire logic                      rst_b_in,
	input  wire logic                      hsel_in,
	input  wire logic [31:0]               haddr_in,
	input  wire logic [1:0]                htrans_in,
	input  wire logic                      hwrite_in,
	input  wire logic [2:0]                hsize_in,
	input  wire logic [31:0]               hwdata_in,
	input  wire logic                      hready_in,
	output      logic                      hreadyout_out,
	output      logic [31:0]               hrdata_out,
	output      logic [1:0]                hresp_out,
	input  wire logic [7:0]                protect_start_in,
	input  wire logic [7:0]                array_rdata_in,
	input  wire logic                      low_power_in,
	input  wire logic                      monitor_locked_in,
	input  wire logic                      test_high_voltage_in,
	output      flash_seq_pkg::array_ctl_s array_ctl_out
);
	import flash_seq_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		seq_e                 seq;
		logic                 prog;
		logic                 erase;
		logic                 mass;
		logic                 hv;
		logic [15:0]          tgt;
		logic [15:0]          addr;
		logic [10:0]          row;
		logic [RCV_CNT_W-1:0] rcv_cnt;
		logic                 seq_err;
		logic                 prot_err;
		logic                 aborted;
		logic                 standby;
		logic                 ph_valid;
		logic                 ph_write;
		logic [ADDR_W-1:0]    ph_addr;
		logic                 rd_wait;
		logic                 hready;
		logic [31:0]          hrdata;
		logic                 tv_meta;
		logic                 tv_sync;
		array_ctl_s           ctl;
	} state_s;

	state_s st_r;
	state_s st_nxt;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [15:0] protect_start(input logic [7:0] pbyte);
		protect_start = {PROT_TOP, pbyte, PROT_LOW};
	endfunction

	function automatic logic is_protected(input logic [15:0] a,
	                                      input logic [7:0]  pbyte,
	                                      input logic        mass,
	                                      input logic        tv);
		logic p;
		p = 1'b0;
		if (tv)
			p = 1'b0;
		else if (pbyte == PROT_NONE)
			p = 1'b0;
		else if (mass || pbyte == PROT_ALL)
			p = 1'b1;
		else if (a == PROT_BYTE_ADDR)
			p = 1'b1;
		else
			p = (a >= protect_start(pbyte));
		is_protected = p;
	endfunction

	function automatic logic [31:0] read_mux(input state_s s,
	                                         input logic [ADDR_W-1:0] a,
	                                         input logic [7:0] pbyte,
	                                         input logic [7:0] rdat);
		logic [31:0] d;
		d = WORD_ZERO;
		case (a)
			FLASH_CTRL_OFS:
			begin
				d[CTRL_PROG_BIT]  = s.prog;
				d[CTRL_ERASE_BIT] = s.erase;
				d[CTRL_MASS_BIT]  = s.mass;
				d[CTRL_HV_BIT]    = s.hv;
			end
			PROTECT_OFS:    d[7:0]  = pbyte;
			ARRAY_ADDR_OFS: d[15:0] = s.addr;
			ARRAY_DATA_OFS: d[7:0]  = rdat;
			STATUS_OFS:
			begin
				d[STAT_SEQ_ERR_BIT]  = s.seq_err;
				d[STAT_PROT_ERR_BIT] = s.prot_err;
				d[STAT_ABORT_BIT]    = s.aborted;
				d[STAT_RCV_BIT]      = (s.rcv_cnt != RCV_ZERO);
				d[STAT_STBY_BIT]     = s.standby;
				d[STAT_SEQ_LSB +: 3] = 3'(s.seq);
			end
			default:        d = WORD_ZERO;
		endcase
		read_mux = d;
	endfunction

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		logic        take;
		logic        w_prog;
		logic        w_erase;
		logic        w_hv;
		logic        prot_hit;
		logic [15:0] wa;
		st_nxt   = st_r;
		take     = hsel_in & htrans_in[1] & hready_in;
		w_prog   = hwdata_in[CTRL_PROG_BIT];
		w_erase  = hwdata_in[CTRL_ERASE_BIT];
		w_hv     = hwdata_in[CTRL_HV_BIT];
		wa       = st_r.addr;
		prot_hit = 1'b0;

		// pin from the high test voltage detector crosses in here
		st_nxt.tv_meta = test_high_voltage_in;
		st_nxt.tv_sync = st_r.tv_meta;

		st_nxt.ctl.wr = 1'b0;
		if (st_r.rcv_cnt != RCV_ZERO)
			st_nxt.rcv_cnt = st_r.rcv_cnt - RCV_ONE;

		// data phase of a write accepted on the previous edge
		if (st_r.ph_valid && st_r.ph_write)
		begin
			case (st_r.ph_addr)
				FLASH_CTRL_OFS:
				begin
					// both at once, or the other already set, is refused
					if (!(w_prog && w_erase))
					begin
						st_nxt.prog  = w_prog & ~st_r.erase;
						st_nxt.erase = w_erase & ~st_r.prog;
					end
					if (!st_r.hv)
						st_nxt.mass = hwdata_in[CTRL_MASS_BIT];
					if (st_nxt.prog || st_nxt.erase)
						st_nxt.standby = 1'b0;
					case (st_r.seq)
						SEQ_IDLE:
							if (st_nxt.prog || st_nxt.erase)
								st_nxt.seq = SEQ_SELECTED;
						SEQ_SELECTED, SEQ_PROT_READ, SEQ_ARMED:
							if (!st_nxt.prog && !st_nxt.erase)
								st_nxt.seq = SEQ_IDLE;
						SEQ_HV:
							if (!st_nxt.prog && !st_nxt.erase)
								st_nxt.seq = SEQ_RELEASE;
						default: st_nxt.seq = st_r.seq;
					endcase
					if (w_hv && !st_r.hv)
					begin
						prot_hit = is_protected(st_r.tgt, protect_start_in,
						                        st_r.mass & st_r.erase,
						                        st_r.tv_sync);
						if (st_r.seq == SEQ_ARMED && !prot_hit &&
						    (st_nxt.prog || st_nxt.erase))
						begin
							st_nxt.hv  = 1'b1;
							st_nxt.seq = SEQ_HV;
						end
						else if (prot_hit && st_r.seq == SEQ_ARMED)
							st_nxt.prot_err = 1'b1;
						else
							st_nxt.seq_err = 1'b1;
					end
					else if (!w_hv && st_r.hv)
					begin
						// dropping hv is always honoured, it is the safe way
						st_nxt.hv      = 1'b0;
						st_nxt.rcv_cnt = RCV_CYCLES;
						if (st_r.seq != SEQ_RELEASE)
							st_nxt.seq_err = 1'b1;
						st_nxt.seq = (st_nxt.prog || st_nxt.erase) ?
						             SEQ_SELECTED : SEQ_IDLE;
					end
				end
				PROTECT_OFS:
				begin
					// the byte itself changes only by array programming
					if (monitor_locked_in && st_r.erase && st_r.mass &&
					    st_r.seq == SEQ_PROT_READ)
					begin
						st_nxt.tgt = PROT_BYTE_ADDR;
						st_nxt.seq = SEQ_ARMED;
					end
					else
						st_nxt.seq_err = 1'b1;
				end
				ARRAY_ADDR_OFS: st_nxt.addr = hwdata_in[15:0];
				ARRAY_DATA_OFS:
				begin
					if (st_r.seq == SEQ_PROT_READ &&
					    !(monitor_locked_in && st_r.erase && st_r.mass))
					begin
						st_nxt.tgt = wa;
						st_nxt.row = wa[15:ROW_LSB];
						st_nxt.seq = SEQ_ARMED;
					end
					else if (st_r.seq == SEQ_HV && st_r.prog &&
					         wa[15:ROW_LSB] == st_r.row)
					begin
						if (is_protected(wa, protect_start_in, 1'b0,
						                 st_r.tv_sync))
							st_nxt.prot_err = 1'b1;
						else
						begin
							st_nxt.ctl.wr    = 1'b1;
							st_nxt.ctl.wdata = hwdata_in[7:0];
						end
					end
					else
						st_nxt.seq_err = 1'b1;
				end
				STATUS_OFS:
				begin
					if (hwdata_in[STAT_SEQ_ERR_BIT])
						st_nxt.seq_err = 1'b0;
					if (hwdata_in[STAT_PROT_ERR_BIT])
						st_nxt.prot_err = 1'b0;
					if (hwdata_in[STAT_ABORT_BIT])
						st_nxt.aborted = 1'b0;
				end
				default: st_nxt.seq = st_r.seq;
			endcase
		end

		// address phase; a new request is only taken while hready is high
		st_nxt.ph_valid = take;
		if (take)
		begin
			st_nxt.ph_write = hwrite_in;
			st_nxt.ph_addr  = haddr_in[ADDR_W-1:0];
			if (!hwrite_in)
			begin
				if (haddr_in[ADDR_W-1:0] == PROTECT_OFS &&
				    st_r.seq == SEQ_SELECTED)
					st_nxt.seq = SEQ_PROT_READ;
				if (haddr_in[ADDR_W-1:0] == ARRAY_DATA_OFS &&
				    st_nxt.rcv_cnt != RCV_ZERO)
				begin
					st_nxt.hready  = 1'b0;
					st_nxt.rd_wait = 1'b1;
				end
				else
					st_nxt.hrdata = read_mux(st_nxt,
					                         haddr_in[ADDR_W-1:0],
					                         protect_start_in,
					                         array_rdata_in);
			end
		end
		else if (st_r.rd_wait && st_r.rcv_cnt == RCV_ZERO)
		begin
			st_nxt.rd_wait = 1'b0;
			st_nxt.hready  = 1'b1;
			st_nxt.hrdata  = {24'h00_0000, array_rdata_in};
		end

		// low-power entry wins over any bus step in the same cycle
		if (low_power_in &&
		    (st_r.seq != SEQ_IDLE || st_r.prog || st_r.erase || st_r.hv))
		begin
			st_nxt.prog    = 1'b0;
			st_nxt.erase   = 1'b0;
			st_nxt.mass    = 1'b0;
			st_nxt.hv      = 1'b0;
			st_nxt.seq     = SEQ_IDLE;
			st_nxt.standby = 1'b1;
			st_nxt.aborted = 1'b1;
			st_nxt.ctl.wr  = 1'b0;
		end

		// array-facing controls; standby forces prog, erase, mass and hv off
		st_nxt.ctl.standby = st_nxt.standby;
		st_nxt.ctl.prog    = st_nxt.prog  & ~st_nxt.standby;
		st_nxt.ctl.erase   = st_nxt.erase & ~st_nxt.standby;
		st_nxt.ctl.mass    = st_nxt.mass  & ~st_nxt.standby;
		st_nxt.ctl.hv      = st_nxt.hv    & ~st_nxt.standby;
		if (st_nxt.ctl.wr || !(st_nxt.hv || st_nxt.seq == SEQ_ARMED))
			st_nxt.ctl.addr = st_nxt.addr;
		else
			st_nxt.ctl.addr = st_nxt.tgt;
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_in)
	begin
		if (!rst_b_in)
		begin
			st_r          <= '0;
			st_r.seq      <= SEQ_IDLE;
			st_r.hready   <= 1'b1;
			st_r.ctl.addr <= ADDR_RESET;
		end
		else
			st_r <= st_nxt;
	end

	assign hreadyout_out = st_r.hready;
	assign hrdata_out    = st_r.hrdata;
	assign hresp_out     = HRESP_OKAY;
	assign array_ctl_out = st_r.ctl;

endmodule

// ===== flash_program_erase_protect_tb.sv
// self-checking bench for the flash sequencer over ahb-lite
`timescale 1ns/1ps

module flash_program_erase_protect_tb;
	import flash_seq_pkg::*;
	logic        clk;
	logic        rst_b;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hready;
	logic [31:0] hrdata;
	logic [7:0]  pbyte;
	logic [7:0]  ardata;
	logic        lowp;
	logic        mlock;
	logic        tv;
	array_ctl_s  ctl;
	logic [31:0] rd;
	logic [15:0] wr_a;
	logic [7:0]  wr_d;
	int          err_count = 0;
	int          n_compared = 0;
	int          stall_n;
	int          wr_n = 0;
	int          n0;
	logic [7:0]  pb_t [9] = '{8'h00, 8'h80, 8'h80, 8'h81, 8'h81,
	                          8'hFE, 8'h00, 8'h81, 8'hFF};
	logic [15:0] ad_t [9] = '{16'h1040, 16'hDFC0, 16'hE000, 16'hE020,
	                          16'hE040, 16'hFF00, 16'h1040, 16'h1040,
	                          16'h1040};
	logic [3:0]  sl_t [9] = '{4'h2, 4'h2, 4'h2, 4'h1, 4'h1, 4'h2,
	                          4'h2, 4'h6, 4'h6};
	logic [8:0]  ok_t = 9'h14A;

	flash_program_erase_protect uut
	(
		.sys_clk_in           (clk),
		.rst_b_in             (rst_b),
		.hsel_in              (hsel),
		.haddr_in             (haddr),
		.htrans_in            (htrans),
		.hwrite_in            (hwrite),
		.hsize_in             (hsize),
		.hwdata_in            (hwdata),
		.hready_in            (hready),
		.hreadyout_out        (hready),
		.hrdata_out           (hrdata),
		.hresp_out            (),
		.protect_start_in     (pbyte),
		.array_rdata_in       (ardata),
		.low_power_in         (lowp),
		.monitor_locked_in    (mlock),
		.test_high_voltage_in (tv),
		.array_ctl_out        (ctl)
	);

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	always @(posedge clk)
		if (ctl.wr === 1'b1)
		begin
			wr_n <= wr_n + 1;
			wr_a <= ctl.addr;
			wr_d <= ctl.wdata;
		end

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic final_report;
		$display("compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			err_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wait_rdy(output int n);
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end while (hready !== 1'b1 && n < 40);
		if (hready !== 1'b1)
		begin
			err_count++;
			final_report();
		end
	endtask

	task automatic bus(input logic [7:0] a, input logic w,
		input logic [31:0] d);
		int n;
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= {24'h00_0000, a};
		hwrite <= w;
		hsize  <= 3'h2;
		wait_rdy(n);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy(n);
		stall_n = n - 1;
		rd = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(a, 1'b1, d);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		bus(a, 1'b0, WORD_ZERO);
		check(rd, exp);
	endtask

	// select, protect read, arm, then ask for hv
	task automatic run_op(input logic [3:0] sel, input logic [7:0] arm,
		input logic [15:0] a, input logic ok);
		wr(FLASH_CTRL_OFS, {28'h000_0000, sel});
		rdc(PROTECT_OFS, {24'h00_0000, pbyte});
		wr(ARRAY_ADDR_OFS, {16'h0000, a});
		wr(arm, 32'h0000_00A5);
		wr(FLASH_CTRL_OFS, {28'h000_0000, sel | 4'h8});
		bus(STATUS_OFS, 1'b0, WORD_ZERO);
		check(32'(rd[STAT_PROT_ERR_BIT]), 32'(!ok));
		check(32'(ctl.hv), 32'(ok));
	endtask

	task automatic finish_op;
		wr(FLASH_CTRL_OFS, 32'h0000_0008);
		wr(FLASH_CTRL_OFS, WORD_ZERO);
		wr(STATUS_OFS, 32'h0000_0007);
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		rst_b = 1'b0;
		hsel = 1'b0;
		haddr = WORD_ZERO;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = WORD_ZERO;
		pbyte = 8'hFF;
		ardata = 8'hFF;
		lowp = 1'b0;
		mlock = 1'b0;
		tv = 1'b0;
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		check(32'(ctl), WORD_ZERO);
		rdc(STATUS_OFS, WORD_ZERO);
		wr(8'h20, 32'hFFFF_FFFF);
		rdc(8'h20, WORD_ZERO);
		run_op(4'h2, ARRAY_DATA_OFS, 16'h1040, 1'b1);
		rdc(STATUS_OFS, 32'h0000_0400);
		finish_op();
		bus(ARRAY_DATA_OFS, 1'b0, WORD_ZERO);
		check(32'(stall_n > 0), 32'h1);
		check(rd, 32'h0000_00FF);
		// a programmed cell must come back as zero
		ardata <= BYTE_ZERO;
		bus(ARRAY_DATA_OFS, 1'b0, WORD_ZERO);
		check(32'(stall_n), WORD_ZERO);
		check(rd, WORD_ZERO);
		wr(FLASH_CTRL_OFS, 32'h0000_0002);
		wr(FLASH_CTRL_OFS, 32'h0000_000A);
		rdc(STATUS_OFS, 32'h0000_0101);
		check(32'(ctl.hv), WORD_ZERO);
		wr(FLASH_CTRL_OFS, 32'h0000_0003);
		@(posedge clk);
		check(32'(ctl.prog), WORD_ZERO);
		check(32'(ctl.erase), 32'h1);
		finish_op();
		// protected ranges, byte lock, test voltage, mass and monitor arm
		for (int i = 0; i < 9; i++)
		begin
			pbyte <= pb_t[i];
			tv <= (i == 6);
			mlock <= (i == 8);
			repeat (4) @(posedge clk);
			n0 = (i == 8) ? PROTECT_OFS : ARRAY_DATA_OFS;
			run_op(sl_t[i], 8'(n0), ad_t[i], ok_t[i]);
			finish_op();
		end
		mlock <= 1'b0;
		// the row is erased before any byte of it is programmed
		run_op(4'h2, ARRAY_DATA_OFS, 16'h2000, 1'b1);
		finish_op();
		run_op(4'h1, ARRAY_DATA_OFS, 16'h2000, 1'b1);
		n0 = wr_n;
		for (int i = 0; i < 2; i++)
		begin
			wr(ARRAY_ADDR_OFS, 32'h0000_2005 + i);
			wr(ARRAY_DATA_OFS, 32'h0000_005A + i);
			repeat (3) @(posedge clk);
			check(32'(wr_a), 32'h0000_2005 + i);
			check(32'(wr_d), 32'h0000_005A + i);
		end
		wr(ARRAY_ADDR_OFS, 32'h0000_2020);
		wr(ARRAY_DATA_OFS, 32'h0000_0011);
		bus(STATUS_OFS, 1'b0, WORD_ZERO);
		check(32'(rd[STAT_SEQ_ERR_BIT]), 32'h1);
		check(wr_n - n0, 32'h2);
		// low power in mid program drops everything to standby
		lowp <= 1'b1;
		@(posedge clk);
		lowp <= 1'b0;
		@(posedge clk);
		check(32'(ctl[29:24]), 32'h1);
		bus(STATUS_OFS, 1'b0, WORD_ZERO);
		check(rd & 32'h0000_0014, 32'h0000_0014);
		wr(FLASH_CTRL_OFS, 32'h0000_0002);
		@(posedge clk);
		check(32'(ctl.standby), WORD_ZERO);
		// the protect byte is array content, a reset must not touch it
		pbyte <= 8'h81;
		rst_b <= 1'b0;
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		check(32'(ctl), WORD_ZERO);
		rdc(STATUS_OFS, WORD_ZERO);
		rdc(PROTECT_OFS, 32'h0000_0081);
		final_report();
	end
endmodule

// ===== flash_seq_monitor.sv
// assertion checker bound to the flash sequencer top
`timescale 1ns/1ps

module flash_seq_monitor
(
	input wire logic                      sys_clk_in,
	input wire logic                      rst_b_in,
	input wire logic                      hreadyout_out,
	input wire logic [7:0]                protect_start_in,
	input wire logic                      low_power_in,
	input wire logic                      test_high_voltage_in,
	input wire flash_seq_pkg::array_ctl_s array_ctl_out
);
	import flash_seq_pkg::*;
	array_ctl_s c;
	logic [3:0] tv_h;
	assign c = array_ctl_out;
	// tv passes a synchroniser, so a recent high still counts
	always_ff @(posedge sys_clk_in)
		tv_h <= {tv_h[2:0], test_high_voltage_in};
	wire tv_any = |{tv_h, test_high_voltage_in};
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_b_in);
	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	AST_INTERLOCK: assert property (!(c.prog && c.erase))
		else $error("program and erase both set");
	AST_HV_SEL: assert property ($rose(c.hv) |-> c.prog || c.erase)
		else $error("hv rose without a select");
	AST_STBY_QUIET: assert property (c.standby |->
		!(c.prog || c.erase || c.mass || c.hv || c.wr))
		else $error("array control active in standby");
	AST_ABORT: assert property (low_power_in &&
		(c.prog || c.erase || c.hv) |=> c.standby && !c.hv)
		else $error("low power did not abort");
	AST_STALL: assert property ($fell(hreadyout_out) |->
		##[1:21] hreadyout_out)
		else $error("recovery stall too long");
	AST_PROTECT: assert property ($rose(c.hv) && !tv_any |->
		protect_start_in != PROT_ALL &&
		(!c.mass || protect_start_in == PROT_NONE))
		else $error("hv set inside protected range");
	AST_STBY_EXIT: assert property ($fell(c.standby) |->
		c.prog || c.erase)
		else $error("standby left without a select");
	AST_MASS_HELD: assert property (c.hv && $past(c.hv) |->
		$stable(c.mass))
		else $error("mass changed under hv");
	AST_WR_HV: assert property (c.wr |-> c.prog && c.hv)
		else $error("program strobe outside program hv");
	COV_HV: cover property ($rose(c.hv));
	COV_STALL: cover property ($fell(hreadyout_out));
	COV_STBY: cover property ($rose(c.standby));
endmodule

bind flash_program_erase_protect flash_seq_monitor mon
(
	.sys_clk_in,
	.rst_b_in,
	.hreadyout_out,
	.protect_start_in,
	.low_power_in,
	.test_high_voltage_in,
	.array_ctl_out
);

// ===== flash_seq_pkg.sv
// shared constants, register map and types of the flash sequencer
package flash_seq_pkg;

	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS     = 50;
	localparam int RCV_TIME_NS       = 1000;
	localparam int RCV_CYCLES_I      = (RCV_TIME_NS + CLK_PERIOD_NS - 1)
	                                   / CLK_PERIOD_NS;
	localparam int RCV_CNT_W         = 5;
	localparam logic [RCV_CNT_W-1:0] RCV_CYCLES = RCV_CYCLES_I[RCV_CNT_W-1:0];
	localparam logic [RCV_CNT_W-1:0] RCV_ZERO   = 5'h0;
	localparam logic [RCV_CNT_W-1:0] RCV_ONE    = 5'h1;

	// ----------------------------------------------------------------
	// register map, byte offsets
	// ----------------------------------------------------------------
	localparam int         ADDR_W          = 8;
	localparam logic [7:0] FLASH_CTRL_OFS  = 8'h00;
	localparam logic [7:0] PROTECT_OFS     = 8'h04;
	localparam logic [7:0] ARRAY_ADDR_OFS  = 8'h08;
	localparam logic [7:0] ARRAY_DATA_OFS  = 8'h0C;
	localparam logic [7:0] STATUS_OFS      = 8'h10;

	// control bits of flash_control_reg
	localparam int CTRL_PROG_BIT  = 0;
	localparam int CTRL_ERASE_BIT = 1;
	localparam int CTRL_MASS_BIT  = 2;
	localparam int CTRL_HV_BIT    = 3;

	// status bits
	localparam int STAT_SEQ_ERR_BIT  = 0;
	localparam int STAT_PROT_ERR_BIT = 1;
	localparam int STAT_ABORT_BIT    = 2;
	localparam int STAT_RCV_BIT      = 3;
	localparam int STAT_STBY_BIT     = 4;
	localparam int STAT_SEQ_LSB      = 8;

	// ----------------------------------------------------------------
	// protect-start byte decode
	// ----------------------------------------------------------------
	localparam logic [7:0]  PROT_ALL     = 8'h00;
	localparam logic [7:0]  PROT_NONE    = 8'hFF;
	localparam logic [1:0]  PROT_TOP     = 2'h3;
	localparam logic [5:0]  PROT_LOW     = 6'h00;
	localparam int          ROW_LSB      = 5;
	localparam logic [15:0] ADDR_RESET   = 16'h0000;
	localparam logic [31:0] WORD_ZERO    = 32'h0000_0000;
	localparam logic [7:0]  BYTE_ZERO    = 8'h00;
	localparam logic [1:0]  HRESP_OKAY   = 2'h0;

	typedef enum logic [2:0] {
		SEQ_IDLE,
		SEQ_SELECTED,
		SEQ_PROT_READ,
		SEQ_ARMED,
		SEQ_HV,
		SEQ_RELEASE
	} seq_e;

	typedef struct packed {
		logic        prog;
		logic        erase;
		logic        mass;
		logic        hv;
		logic        wr;
		logic        standby;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} array_ctl_s;

endpackage
